//--- rtl/ptt_pkg.sv
// Purpose: shared constants and types for the position task table sequencer
// Assumes: 40 MHz clock, plain register port with one-cycle read latency
// Notes: task fields are reached through a slot select plus a field address
package ptt_pkg;
	localparam int unsigned PTT_SLOTS = 32;
	localparam int unsigned PTT_SLOT_W = 5;
	localparam int unsigned PTT_PROF = 8;
	localparam int unsigned PTT_PROF_W = 3;
	localparam int unsigned PTT_DATA_W = 32;
	localparam int unsigned PTT_ADDR_W = 8;
	// Control word fields
	localparam int unsigned CW_NEXT_LSB = 0;
	localparam int unsigned CW_CHAIN_BIT = 8;
	localparam int unsigned CW_LVL_BIT = 9;
	localparam int unsigned CW_EDGE_BIT = 10;
	localparam int unsigned CW_AND_BIT = 11;
	localparam int unsigned CW_MODE_LSB = 12;
	localparam int unsigned CW_POL_LSB = 14;
	// Register addresses
	localparam logic [7:0] REG_SLOT_SEL = 8'h00;
	localparam logic [7:0] REG_POSITION = 8'h04;
	localparam logic [7:0] REG_SPEED = 8'h08;
	localparam logic [7:0] REG_DELAY = 8'h0C;
	localparam logic [7:0] REG_PROFILE = 8'h10;
	localparam logic [7:0] REG_CTRL = 8'h14;
	localparam logic [7:0] REG_LOOPS = 8'h18;
	localparam logic [7:0] REG_REMAIN = 8'h1C;
	localparam logic [7:0] REG_ENTRY = 8'h20;
	localparam logic [7:0] REG_STATUS = 8'h24;
	localparam logic [7:0] REG_DONE = 8'h28;
	localparam logic [7:0] REG_RATE_BASE = 8'h40;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
	// One millisecond of clock cycles
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned MS_PER_S = 1000;
	localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
	localparam logic [15:0] MS_TICK_LAST = 16'(CYC_PER_MS - 1);

	typedef enum logic [1:0] {
		POS_ABS = 2'h0,
		POS_REL_TARGET = 2'h1,
		POS_REL_ACTUAL = 2'h2,
		POS_RSVD = 2'h3
	} ptt_mode_type;

	typedef enum logic [1:0] {
		POL_IGNORE = 2'h0,
		POL_WAIT = 2'h1,
		POL_ABORT = 2'h2,
		POL_RSVD = 2'h3
	} ptt_policy_type;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_RUN = 4'b0010,
		ST_DELAY = 4'b0100,
		ST_DECIDE = 4'b1000
	} ptt_state_type;

	typedef struct packed {
		logic [15:0] ctrl;
		logic [15:0] loops;
		logic [15:0] delay_ms;
		logic [PTT_PROF_W-1:0] acc_sel;
		logic [PTT_PROF_W-1:0] dec_sel;
	} ptt_task_type;

	typedef struct packed {
		logic valid;
		logic [31:0] position;
		logic [31:0] speed;
		logic [31:0] acc_rate;
		logic [31:0] dec_rate;
		ptt_mode_type mode;
	} ptt_cmd_type;

	typedef struct packed {
		logic [PTT_ADDR_W-1:0] addr;
		logic [PTT_DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} ptt_bus_type;
endpackage

//--- rtl/ptt_sequencer.sv
// Purpose: runs a 32-slot table of positioning tasks under digital-input control
// Assumes: motion engine reports completion with move_done; inputs are asynchronous pins
// Notes: the motion engine itself lives elsewhere; this block only issues commands
module ptt_sequencer (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Register port
	input wire ptt_pkg::ptt_bus_type bus,
	output logic [ptt_pkg::PTT_DATA_W-1:0] rdata,
	// Digital input pins
	input wire logic table_start_input,
	input wire logic table_abort_input,
	input wire logic level_condition_input,
	input wire logic edge_condition_input,
	input wire logic start_function_assigned,
	// Controller events
	input wire logic fault,
	input wire logic op_mode_changed,
	input wire logic move_done,
	// Motion command out
	output ptt_pkg::ptt_cmd_type cmd,
	output logic [ptt_pkg::PTT_SLOT_W-1:0] current_slot,
	output logic flow_running
);
	import ptt_pkg::*;

	logic [31:0] pos_mem [PTT_SLOTS];
	logic [31:0] spd_mem [PTT_SLOTS];
	ptt_task_type task_mem [PTT_SLOTS];
	logic [15:0] remain_ff [PTT_SLOTS];
	logic [31:0] rate_ff [2*PTT_PROF];
	logic [PTT_SLOT_W-1:0] sel_ff, entry_ff, cur_ff, pend_slot_ff;
	logic pend_ff, abort_req_ff, last_ff, run_ff;
	logic [15:0] tick_ff, ms_left_ff;
	ptt_state_type state_ff, nxt_state;
	ptt_cmd_type cmd_ff;
	logic [31:0] rdata_ff;
	logic [3:0] s1_ff, s2_ff, s3_ff;
	logic fn_prev_ff;

	// Pin synchronisers, third stage only for edge detection
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s1_ff <= 4'h0;
			s2_ff <= 4'h0;
			s3_ff <= 4'h0;
			fn_prev_ff <= 1'b0;
		end else begin
			s1_ff <= {table_start_input, table_abort_input,
				level_condition_input, edge_condition_input};
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			fn_prev_ff <= start_function_assigned;
		end
	end
	wire start_rise = s2_ff[3] & ~s3_ff[3];
	wire abort_rise = s2_ff[2] & ~s3_ff[2];
	wire fn_removed = fn_prev_ff & ~start_function_assigned;
	wire lvl_cond = s2_ff[1];
	wire edge_rise = s2_ff[0] & ~s3_ff[0];

	// Bus decode
	wire wr_sel = bus.wr & (bus.addr == REG_SLOT_SEL);
	wire wr_pos = bus.wr & (bus.addr == REG_POSITION);
	wire wr_spd = bus.wr & (bus.addr == REG_SPEED);
	wire wr_dly = bus.wr & (bus.addr == REG_DELAY);
	wire wr_prof = bus.wr & (bus.addr == REG_PROFILE);
	wire wr_ctl = bus.wr & (bus.addr == REG_CTRL);
	wire wr_loop = bus.wr & (bus.addr == REG_LOOPS);
	wire wr_entry = bus.wr & (bus.addr == REG_ENTRY);
	// Sixteen rate words: acceleration then deceleration, eight words apart
	wire rate_hit = (bus.addr[7:6] == REG_RATE_BASE[7:6]) & (bus.addr[1:0] == 2'h0);
	wire [3:0] rate_idx = bus.addr[5:2];
	ptt_task_type sel_task;
	assign sel_task = task_mem[sel_ff];

	// Current task fields
	ptt_task_type cur_task;
	assign cur_task = task_mem[cur_ff];
	wire [15:0] cw = cur_task.ctrl;
	wire [PTT_SLOT_W-1:0] next_slot = cw[CW_NEXT_LSB +: PTT_SLOT_W];
	wire lvl_on = cw[CW_LVL_BIT];
	wire edge_on = cw[CW_EDGE_BIT];
	wire cond_both = cw[CW_AND_BIT] ? (lvl_cond & edge_rise) : (lvl_cond | edge_rise);
	wire cond = (lvl_on & edge_on) ? cond_both : lvl_on ? lvl_cond :
		edge_on ? edge_rise : 1'b1;
	// Loop check on the task about to be entered
	wire next_capped = (task_mem[next_slot].loops != 16'h0000) &&
		(remain_ff[next_slot] == 16'h0000);
	wire chain_ok = cw[CW_CHAIN_BIT] & cond & ~next_capped & ~abort_req_ff;
	ptt_policy_type trig_pol;
	assign trig_pol = ptt_policy_type'(task_mem[entry_ff].ctrl[CW_POL_LSB +: 2]);
	wire entry_capped = (task_mem[entry_ff].loops != 16'h0000) &&
		(remain_ff[entry_ff] == 16'h0000);
	wire busy = (state_ff != ST_IDLE);
	wire kill = fault | op_mode_changed;
	wire trig_abort = start_rise & busy & (trig_pol == POL_ABORT);
	wire trig_wait = start_rise & busy & (trig_pol == POL_WAIT);
	wire new_flow = start_rise & ~busy;
	wire ms_tick = (tick_ff == MS_TICK_LAST);
	wire launch_pend = (state_ff == ST_RUN) & move_done & pend_ff;
	wire load_first = new_flow | trig_abort;
	wire [PTT_SLOT_W-1:0] launch_slot = launch_pend ? pend_slot_ff :
		load_first ? entry_ff : next_slot;

	// Sequencer state
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_IDLE: if (new_flow) nxt_state = ST_RUN;
			ST_RUN: if (trig_abort) nxt_state = ST_RUN;
				else if (launch_pend) nxt_state = ST_RUN;
				else if (move_done) nxt_state = (cur_task.delay_ms == 16'h0000) ?
					ST_DECIDE : ST_DELAY;
			ST_DELAY: if (trig_abort) nxt_state = ST_RUN;
				else if (ms_tick && ms_left_ff == 16'h0001) nxt_state = ST_DECIDE;
			ST_DECIDE: if (trig_abort) nxt_state = ST_RUN;
				else nxt_state = chain_ok ? ST_RUN : ST_IDLE;
		endcase
		if (kill) nxt_state = ST_IDLE;
	end
	wire start_task = ~kill & ((load_first) | launch_pend |
		(state_ff == ST_DECIDE && chain_ok && !trig_abort));

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_ff <= ST_IDLE;
			run_ff <= 1'b0;
			cur_ff <= '0;
			pend_ff <= 1'b0;
			pend_slot_ff <= '0;
			abort_req_ff <= 1'b0;
			tick_ff <= 16'h0000;
			ms_left_ff <= 16'h0000;
		end else begin
			state_ff <= nxt_state;
			// Registered copy of busy so the status pin comes from a flop
			run_ff <= (nxt_state != ST_IDLE);
			tick_ff <= (state_ff == ST_DELAY && !ms_tick) ? tick_ff + 16'h0001 : 16'h0000;
			if (state_ff == ST_RUN && move_done)
				ms_left_ff <= cur_task.delay_ms;
			else if (state_ff == ST_DELAY && ms_tick)
				ms_left_ff <= ms_left_ff - 16'h0001;
			if (start_task)
				cur_ff <= launch_slot;
			// A trigger that meets a pending launch queues again, set beats every clear except kill
			if (kill)
				pend_ff <= 1'b0;
			else if (trig_wait && (!pend_ff || launch_pend)) begin
				pend_ff <= 1'b1;
				pend_slot_ff <= entry_ff;
			end else if (new_flow || launch_pend || trig_abort)
				pend_ff <= 1'b0;
			// Abort request waits for the running task, set beats clear
			if (abort_rise || (fn_removed && busy))
				abort_req_ff <= 1'b1;
			else if (new_flow || nxt_state == ST_IDLE)
				abort_req_ff <= 1'b0;
		end
	end

	// Command output; entry of a capped task still launched, only flagged in last_ff
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cmd_ff <= '0;
			last_ff <= 1'b0;
		end else begin
			cmd_ff.valid <= start_task;
			if (start_task) begin
				cmd_ff.position <= pos_mem[launch_slot];
				cmd_ff.speed <= spd_mem[launch_slot];
				cmd_ff.acc_rate <= rate_ff[{1'b0, task_mem[launch_slot].acc_sel}];
				cmd_ff.dec_rate <= rate_ff[{1'b1, task_mem[launch_slot].dec_sel}];
				cmd_ff.mode <= ptt_mode_type'(task_mem[launch_slot].ctrl[CW_MODE_LSB +: 2]);
			end
			last_ff <= entry_capped;
		end
	end

	// Table storage and remaining counters
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sel_ff <= '0;
			entry_ff <= '0;
			for (int i = 0; i < PTT_SLOTS; i++) begin
				pos_mem[i] <= ZERO_WORD;
				spd_mem[i] <= ZERO_WORD;
				task_mem[i] <= '0;
				remain_ff[i] <= 16'h0000;
			end
			for (int j = 0; j < 2*PTT_PROF; j++)
				rate_ff[j] <= ZERO_WORD;
		end else begin
			if (wr_sel) sel_ff <= bus.wdata[PTT_SLOT_W-1:0];
			if (wr_entry) entry_ff <= bus.wdata[PTT_SLOT_W-1:0];
			if (wr_pos) pos_mem[sel_ff] <= bus.wdata;
			if (wr_spd) spd_mem[sel_ff] <= bus.wdata;
			if (wr_dly) task_mem[sel_ff].delay_ms <= bus.wdata[15:0];
			if (wr_prof) begin
				task_mem[sel_ff].acc_sel <= bus.wdata[2:0];
				task_mem[sel_ff].dec_sel <= bus.wdata[6:4];
			end
			if (wr_ctl) task_mem[sel_ff].ctrl <= bus.wdata[15:0];
			if (wr_loop) task_mem[sel_ff].loops <= bus.wdata[15:0];
			if (bus.wr && rate_hit) rate_ff[rate_idx] <= bus.wdata;
			if (new_flow) begin
				for (int i = 0; i < PTT_SLOTS; i++)
					remain_ff[i] <= task_mem[i].loops;
			end
			// Entry of a new flow counts even when the old count ran out
			if (start_task && task_mem[launch_slot].loops != 16'h0000 &&
					(new_flow || remain_ff[launch_slot] != 16'h0000))
				remain_ff[launch_slot] <= (new_flow ? task_mem[launch_slot].loops :
					remain_ff[launch_slot]) - 16'h0001;
		end
	end

	// Read mux, one cycle latency
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = ZERO_WORD;
		unique case (bus.addr)
			REG_SLOT_SEL: rd_mux = {27'h000_0000, sel_ff};
			REG_POSITION: rd_mux = pos_mem[sel_ff];
			REG_SPEED: rd_mux = spd_mem[sel_ff];
			REG_DELAY: rd_mux = {16'h0000, sel_task.delay_ms};
			REG_PROFILE: rd_mux = {25'h000_0000, sel_task.dec_sel, 1'b0, sel_task.acc_sel};
			REG_CTRL: rd_mux = {16'h0000, sel_task.ctrl};
			REG_LOOPS: rd_mux = {16'h0000, sel_task.loops};
			REG_REMAIN: rd_mux = {16'h0000, remain_ff[sel_ff]};
			REG_ENTRY: rd_mux = {27'h000_0000, entry_ff};
			REG_STATUS: rd_mux = {22'h00_0000, last_ff, abort_req_ff, pend_ff,
				busy, state_ff[3:3], cur_ff};
			default: rd_mux = rate_hit ? rate_ff[rate_idx] : ZERO_WORD;
		endcase
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) rdata_ff <= ZERO_WORD;
		else rdata_ff <= bus.rd ? rd_mux : ZERO_WORD;
	end

	assign rdata = rdata_ff;
	assign cmd = cmd_ff;
	assign current_slot = cur_ff;
	assign flow_running = run_ff;

	chk_kill_idle: assert property (@(posedge clk) disable iff (!resetn)
		kill |=> state_ff == ST_IDLE) else $error("flow not ended on fault");
	chk_ignore_start: assert property (@(posedge clk) disable iff (!resetn)
		start_rise && busy && (trig_pol == POL_IGNORE || trig_pol == POL_RSVD) && !kill
		&& state_ff != ST_DECIDE && !launch_pend |=> !cmd_ff.valid && $stable(pend_ff))
		else $error("ignored trigger restarted task");
	chk_stop_bit: assert property (@(posedge clk) disable iff (!resetn)
		state_ff == ST_DECIDE && !cw[CW_CHAIN_BIT] && !trig_abort |=> state_ff == ST_IDLE)
		else $error("stop bit did not stop flow");
	chk_capped_stop: assert property (@(posedge clk) disable iff (!resetn)
		state_ff == ST_DECIDE && next_capped && !trig_abort |=> state_ff == ST_IDLE)
		else $error("capped task entered");
	chk_new_flow: assert property (@(posedge clk) disable iff (!resetn)
		new_flow && !kill |=> cmd_ff.valid && cur_ff == $past(entry_ff))
		else $error("start edge did not launch entry");
	chk_abort_now: assert property (@(posedge clk) disable iff (!resetn)
		trig_abort && !kill |=> cmd_ff.valid && state_ff == ST_RUN)
		else $error("abort policy did not restart");
	chk_abort_hold: assert property (@(posedge clk) disable iff (!resetn)
		abort_req_ff && state_ff == ST_DECIDE && !trig_abort |=> state_ff == ST_IDLE)
		else $error("abort request ignored");
	chk_zero_delay: assert property (@(posedge clk) disable iff (!resetn)
		state_ff == ST_RUN && move_done && !pend_ff && !trig_abort && !kill &&
		cur_task.delay_ms == 16'h0000 |=> state_ff == ST_DECIDE)
		else $error("zero delay entered wait");
	chk_pend_launch: assert property (@(posedge clk) disable iff (!resetn)
		launch_pend && !kill |=> cmd_ff.valid && cur_ff == $past(pend_slot_ff))
		else $error("queued trigger not launched");
	chk_chain_next: assert property (@(posedge clk) disable iff (!resetn)
		state_ff == ST_DECIDE && chain_ok && !trig_abort && !kill
		|=> cmd_ff.valid && cur_ff == $past(next_slot))
		else $error("chain did not follow next slot");
	chk_loop_reload: assert property (@(posedge clk) disable iff (!resetn)
		new_flow && !kill && task_mem[entry_ff].loops != 16'h0000
		|=> remain_ff[$past(entry_ff)] == $past(task_mem[entry_ff].loops) - 16'h0001)
		else $error("loop counter not reloaded");
	cov_chain: cover property (@(posedge clk) state_ff == ST_DECIDE ##1 cmd_ff.valid);
	cov_wait: cover property (@(posedge clk) launch_pend);
	cov_abort: cover property (@(posedge clk) trig_abort);
	cov_delay: cover property (@(posedge clk) state_ff == ST_DELAY ##1 state_ff == ST_DECIDE);
endmodule

//--- test/ptt_equipment.sv
// Purpose: external equipment on the input pins and the motion side
// Assumes: one move in flight at a time
// Notes: lat sets the move length; pins idle low
module ptt_equipment (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Sequencer side
	input wire logic cmd_valid,
	output logic move_done,
	// Pins
	output logic table_start_input,
	output logic table_abort_input,
	output logic level_condition_input,
	output logic edge_condition_input
);
	timeunit 1ns;
	timeprecision 1ps;
	int lat = 3;
	bit edge_on;
	int cnt_ff;
	initial begin
		table_start_input = 1'b0;
		table_abort_input = 1'b0;
		level_condition_input = 1'b0;
	end
	// Held four cycles so the synchroniser cannot miss it
	task automatic pulse(input bit abort);
		@(posedge clk);
		if (abort)
			table_abort_input <= 1'b1;
		else
			table_start_input <= 1'b1;
		repeat (4) @(posedge clk);
		table_abort_input <= 1'b0;
		table_start_input <= 1'b0;
	endtask
	// A relaunch restarts the move, as an interrupted task would
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_ff <= 0;
			move_done <= 1'b0;
			edge_condition_input <= 1'b0;
		end else begin
			move_done <= (cnt_ff == 1);
			// Edge reaches the sequencer in the decision cycle after move_done
			edge_condition_input <= edge_on && (cnt_ff == 2);
			if (cmd_valid)
				cnt_ff <= lat;
			else if (cnt_ff != 0)
				cnt_ff <= cnt_ff - 1;
		end
	end
endmodule

//--- test/ptt_sequencer_test.sv
// Purpose: self-checking bench for the task table sequencer
// Assumes: equipment model answers each launch with move_done
// Notes: a monitor checks launches and reads against queued notes
module ptt_sequencer_test;
	import ptt_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, resetn, fault, op_mode_changed, move_done, fn_on, rd_d;
	ptt_bus_type bus;
	logic [31:0] rdata;
	ptt_cmd_type cmd;
	logic [4:0] current_slot;
	logic flow_running;
	wire st, ab, lv, ed;
	logic [134:0] lq[$];
	logic [31:0] rq[$];
	int miscompares, comparisons;
	logic [31:0] seed = 32'h0000_0017;
	logic [31:0] acc_r[8], dec_r[8], pos_r[32], spd_r[32];
	logic [15:0] ctrl_r[32];
	logic [7:0] prof_r[32];
	logic [15:0] cw_t[10] = '{16'h0200, 16'h0200, 16'h0E00, 16'h0600, 16'h0400, 16'h0000,
		16'h0400, 16'h0E00, 16'h0E00, 16'h0600};
	bit lv_t[10] = '{0, 1, 1, 1, 1, 0, 0, 1, 0, 0};
	bit ed_t[10] = '{0, 0, 0, 0, 0, 0, 1, 1, 1, 1};
	bit go_t[10] = '{0, 1, 0, 1, 0, 1, 1, 1, 0, 1};
	time t_last, t_gap;

	ptt_sequencer dut (.clk(clk), .resetn(resetn), .bus(bus), .rdata(rdata),
		.table_start_input(st), .table_abort_input(ab), .level_condition_input(lv),
		.edge_condition_input(ed), .start_function_assigned(fn_on), .fault(fault),
		.op_mode_changed(op_mode_changed), .move_done(move_done), .cmd(cmd),
		.current_slot(current_slot), .flow_running(flow_running));
	ptt_equipment eq (.clk(clk), .resetn(resetn), .cmd_valid(cmd.valid),
		.move_done(move_done), .table_start_input(st), .table_abort_input(ab),
		.level_condition_input(lv), .edge_condition_input(ed));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk_launch(input logic [134:0] got, input logic [134:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_read(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Results are sampled one edge after the design launches them
	always @(posedge clk) begin
		if (cmd.valid === 1'b1) begin
			chk_launch({current_slot, cmd.mode, cmd.position, cmd.speed, cmd.acc_rate,
				cmd.dec_rate}, lq.size() > 0 ? lq.pop_front() : 'x);
			t_gap = $time - t_last;
			t_last = $time;
		end
		if (rd_d)
			chk_read(rdata, rq.pop_front());
		rd_d <= bus.rd;
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back(e);
		@(posedge clk);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clk);
		bus.rd <= 1'b0;
	endtask

	task automatic set_task(input logic [4:0] s, input logic [15:0] c, input logic [15:0] l,
			input logic [15:0] d);
		logic [31:0] p;
		p = rnd();
		pos_r[s] = rnd();
		spd_r[s] = rnd();
		prof_r[s] = {1'b0, p[6:4], 1'b0, p[2:0]};
		ctrl_r[s] = c;
		wr(REG_SLOT_SEL, 32'(s));
		wr(REG_POSITION, pos_r[s]);
		wr(REG_SPEED, spd_r[s]);
		wr(REG_DELAY, 32'(d));
		wr(REG_PROFILE, 32'(prof_r[s]));
		wr(REG_CTRL, 32'(c));
		wr(REG_LOOPS, 32'(l));
	endtask

	task automatic expect_launch(input logic [4:0] s);
		lq.push_back({s, ctrl_r[s][13:12], pos_r[s], spd_r[s], acc_r[prof_r[s][2:0]],
			dec_r[prof_r[s][6:4]]});
	endtask

	task automatic start(input logic [4:0] s);
		wr(REG_ENTRY, 32'(s));
		eq.pulse(1'b0);
	endtask

	task automatic done(input string name);
		repeat (8) @(posedge clk);
		for (int i = 0; i < 60000 && flow_running !== 1'b0; i++)
			@(posedge clk);
		chk_read({31'h0, flow_running}, ZERO_WORD);
		repeat (4) @(posedge clk);
		chk_read(32'(lq.size()), ZERO_WORD);
		$display("test %s finished", name);
	endtask

	initial begin
		resetn = 1'b0;
		bus = '0;
		fault = 1'b0;
		op_mode_changed = 1'b0;
		fn_on = 1'b1;
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			acc_r[i] = rnd();
			dec_r[i] = rnd();
			wr(REG_RATE_BASE + 8'(4 * i), acc_r[i]);
			wr(8'h60 + 8'(4 * i), dec_r[i]);
		end
		wr(REG_SLOT_SEL, 32'h0000_001F);
		wr(REG_CTRL, 32'h0000_A5C3);
		rd(REG_CTRL, 32'h0000_A5C3);
		wr(REG_REMAIN, 32'h0000_0005);
		rd(REG_REMAIN, ZERO_WORD);
		rd(REG_DONE, ZERO_WORD);
		rd(REG_RATE_BASE + 8'h1C, acc_r[7]);
		rd(8'h7C, dec_r[7]);
		done("registers");
		// Reserved bits set on slot 0 must not change the next slot
		set_task(0, 16'h01E1, 0, 0);
		set_task(1, 16'h1102, 0, 0);
		set_task(2, 16'h2000, 0, 0);
		for (int s = 0; s < 3; s++)
			expect_launch(5'(s));
		start(0);
		done("chain");
		set_task(3, 16'h0103, 2, 0);
		for (int k = 0; k < 2; k++) begin
			expect_launch(3);
			expect_launch(3);
			start(3);
			done("loops");
			rd(REG_REMAIN, ZERO_WORD);
		end
		set_task(5, 16'h0000, 0, 0);
		for (int k = 0; k < 10; k++) begin
			set_task(4, 16'h0105 | cw_t[k], 0, 0);
			eq.level_condition_input <= lv_t[k];
			eq.edge_on <= ed_t[k];
			expect_launch(4);
			if (go_t[k])
				expect_launch(5);
			start(4);
			done("conditions");
		end
		eq.edge_on <= 1'b0;
		eq.lat = 60;
		for (int p = 0; p < 4; p++) begin
			set_task(6, {2'(p), 14'h0000}, 0, 0);
			expect_launch(6);
			if (p == 1 || p == 2)
				expect_launch(6);
			start(6);
			repeat (20) @(posedge clk);
			eq.pulse(1'b0);
			done("policy");
		end
		eq.lat = 30;
		set_task(7, 16'h0107, 0, 0);
		for (int k = 0; k < 2; k++) begin
			expect_launch(7);
			start(7);
			if (k == 0)
				eq.pulse(1'b1);
			else
				fn_on <= 1'b0;
			done("abort");
			fn_on <= 1'b1;
		end
		eq.lat = 200;
		for (int k = 0; k < 2; k++) begin
			expect_launch(7);
			start(7);
			repeat (10) @(posedge clk);
			if (k == 0)
				fault <= 1'b1;
			else
				op_mode_changed <= 1'b1;
			@(posedge clk);
			fault <= 1'b0;
			op_mode_changed <= 1'b0;
			@(negedge clk);
			chk_read({31'h0, flow_running}, ZERO_WORD);
			repeat (250) @(posedge clk);
			done("stop at once");
		end
		eq.lat = 3;
		set_task(8, 16'h0109, 0, 1);
		set_task(9, 16'h0000, 0, 0);
		expect_launch(8);
		expect_launch(9);
		start(8);
		done("delay");
		// One millisecond plus the move and the decision cycles
		chk_read({31'h0, t_gap >= 1000000 && t_gap <= 1000500}, 32'h0000_0001);
		print_verdict();
	end

	// Whole run is about 45000 cycles, mostly the delay test; limit is 80000
	initial begin
		#2_000_000;
		miscompares++;
		print_verdict();
	end
endmodule
